// File: hw/sacr_bank.sv
// control and status register bank of the sensor converter, ahb-lite slave
// assumes the analog chain reports results and busy; pad pins are external
`timescale 1ns/1ps
`include "sacr_regs.svh"

module sacr_bank #(
	parameter int DEF_CONV_CTRL = `SACR_RST_CONV_CTRL,
	parameter int DEF_BIAS_EN = `SACR_RST_BIAS_EN,
	parameter int DEF_RATE_S2 = `SACR_RST_RATE_S2,
	parameter int DEF_GAIN_S13 = `SACR_RST_GAIN_S13,
	parameter int DEF_S3_OFS = `SACR_RST_S3_OFS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pad0_in,
	input wire logic pad1_in,
	output logic pad0_out,
	output logic pad0_oe,
	output logic pad1_out,
	output logic pad1_oe,
	output logic osc_enable,
	output logic conv_start,
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire logic [15:0] conv_result,
	input wire logic pump_settled_in,
	input wire logic pump_running_in,
	input wire logic elem_conv_tick,
	output logic pump_force_on_out,
	output logic pump_force_off_out,
	output logic chop_state,
	output logic reference_out_on_pad0,
	output logic reference_in_on_pad1,
	output logic [1:0] elementary_conv_count,
	output logic [2:0] oversample_ratio_code,
	output logic continuous_mode,
	output logic [1:0] converter_bias_sel,
	output logic [1:0] amplifier_bias_sel,
	output logic [3:0] stage_enable,
	output logic [1:0] sample_freq_sel,
	output logic [1:0] stage2_gain,
	output logic [3:0] stage2_offset,
	output logic stage1_gain,
	output logic [6:0] stage3_gain,
	output logic [6:0] stage3_offset_code,
	output logic [4:0] input_channel_sel,
	output logic reference_source_sel
);
	import sacr_pkg::*;

	// ==========================================
	// bus slave
	logic wr_pend_q;
	logic [7:0] wr_idx_q;
	logic [7:0] osc_q, pad_out_q, conv_ctrl_q, bias_en_q, rate_s2_q;
	logic [7:0] gain_s13_q, s3_ofs_q, mux_q, mode_q;
	logic [15:0] result_q;
	logic [1:0] pad0_sync_q, pad1_sync_q;
	logic pump_settled_q1, pump_settled_q2, pump_running_q1, pump_running_q2;
	logic chop_q;
	logic half_q;
	sacr_conv_state_type conv_q;
	logic busy;
	logic acc;
	logic [7:0] acc_idx;
	logic [7:0] wbyte;

	function automatic logic [7:0] word_index(input logic [31:0] a);
		word_index = a[9:2];
	endfunction : word_index

	// single-cycle answer; every access completes with okay
	assign hreadyout = 1'b1;
	assign hresp = `SACR_HRESP_OKAY;
	assign acc = clk_en && hsel && hready && htrans == `SACR_HTRANS_NONSEQ && hsize == `SACR_HSIZE_WORD;
	assign acc_idx = word_index(haddr);
	assign wbyte = hwdata[7:0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
		end else if (clk_en) begin
			wr_pend_q <= acc && hwrite;
			wr_idx_q <= acc_idx;
		end
	end

	// read data is captured in the address phase so it stands from a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (acc && !hwrite) begin
			hrdata <= {24'h000000, read_mux(acc_idx)};
		end
	end

	function automatic logic [7:0] read_mux(input logic [7:0] idx);
		unique case (idx)
			`SACR_IDX_OSC: read_mux = osc_q;
			`SACR_IDX_PAD_OUT: read_mux = pad_out_q;
			`SACR_IDX_PAD_IN: read_mux = {6'h00, pad1_sync_q[1], pad0_sync_q[1]};
			`SACR_IDX_RES_LO: read_mux = result_q[7:0];
			`SACR_IDX_RES_HI: read_mux = result_q[15:8];
			`SACR_IDX_CONV_CTRL: read_mux = conv_ctrl_q;
			`SACR_IDX_BIAS_EN: read_mux = bias_en_q;
			`SACR_IDX_RATE_S2: read_mux = rate_s2_q;
			`SACR_IDX_GAIN_S13: read_mux = gain_s13_q;
			`SACR_IDX_S3_OFS: read_mux = s3_ofs_q;
			`SACR_IDX_MUX_STAT: read_mux = {busy, mux_q[6:0]};
			`SACR_IDX_MODE: read_mux = {pump_settled_q2, pump_running_q2, mode_q[5:0]};
			default: read_mux = 8'h00;
		endcase
	endfunction : read_mux

	// ==========================================
	// configuration registers
	logic wr;
	assign wr = clk_en && wr_pend_q;

	// decoded once, shared by every register and the start sequencer
	function automatic logic wr_hit(input logic [7:0] idx);
		wr_hit = wr && wr_idx_q == idx;
	endfunction : wr_hit

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			osc_q <= `SACR_RST_OSC;
		end else if (wr_hit(`SACR_IDX_OSC)) begin
			osc_q <= wbyte & `SACR_WM_OSC;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad_out_q <= `SACR_RST_PAD_OUT;
		end else if (wr_hit(`SACR_IDX_PAD_OUT)) begin
			pad_out_q <= wbyte & `SACR_WM_PAD_OUT;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bias_en_q <= `SACR_RST_BIAS_EN;
		end else if (wr_hit(`SACR_IDX_BIAS_EN)) begin
			bias_en_q <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rate_s2_q <= `SACR_RST_RATE_S2;
		end else if (wr_hit(`SACR_IDX_RATE_S2)) begin
			rate_s2_q <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gain_s13_q <= `SACR_RST_GAIN_S13;
		end else if (wr_hit(`SACR_IDX_GAIN_S13)) begin
			gain_s13_q <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s3_ofs_q <= `SACR_RST_S3_OFS;
		end else if (wr_hit(`SACR_IDX_S3_OFS)) begin
			s3_ofs_q <= wbyte & `SACR_WM_S3_OFS;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mux_q <= `SACR_RST_MUX;
		end else if (wr_hit(`SACR_IDX_MUX_STAT)) begin
			mux_q <= wbyte & `SACR_WM_MUX;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= `SACR_RST_MODE;
		end else if (wr_hit(`SACR_IDX_MODE)) begin
			mode_q <= wbyte & `SACR_WM_MODE;
		end
	end

	// ==========================================
	// conversion control and start sequencing
	// start bit stays set until a conversion completes with continuous mode clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv_ctrl_q <= `SACR_RST_CONV_CTRL;
		end else if (clk_en) begin
			if (wr_hit(`SACR_IDX_CONV_CTRL)) begin
				conv_ctrl_q <= wbyte & `SACR_WM_CONV_CTRL;
			end else if (conv_q == SACR_CONV_DONE && !conv_ctrl_q[`SACR_B_CONTINUOUS_MODE]) begin
				conv_ctrl_q[`SACR_B_START] <= 1'b0;
			end
		end
	end

	// continuous mode restarts after each result
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv_q <= SACR_CONV_IDLE;
			conv_start <= 1'b0;
		end else if (clk_en) begin
			conv_start <= 1'b0;
			unique case (conv_q)
				SACR_CONV_IDLE: begin
					if (conv_ctrl_q[`SACR_B_START] && !wr_hit(`SACR_IDX_CONV_CTRL)) begin
						conv_start <= 1'b1;
						conv_q <= SACR_CONV_RUN;
					end
				end
				SACR_CONV_RUN: begin
					if (conv_done) conv_q <= SACR_CONV_DONE;
				end
				SACR_CONV_DONE: begin
					conv_q <= SACR_CONV_IDLE;
				end
				default: conv_q <= SACR_CONV_IDLE;
			endcase
		end
	end

	// busy from sequencer or analog side
	assign busy = conv_q != SACR_CONV_IDLE || conv_busy;

	// analog side delivers saturated two's complement
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_q <= 16'h0000;
		end else if (clk_en && conv_q == SACR_CONV_RUN && conv_done) begin
			result_q <= conv_result;
		end
	end

	// ==========================================
	// input synchronisers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad0_sync_q <= 2'b00;
			pad1_sync_q <= 2'b00;
			pump_settled_q1 <= 1'b1;
			pump_settled_q2 <= 1'b1;
			pump_running_q1 <= 1'b0;
			pump_running_q2 <= 1'b0;
		end else if (clk_en) begin
			pad0_sync_q <= {pad0_sync_q[0], pad0_in};
			pad1_sync_q <= {pad1_sync_q[0], pad1_in};
			pump_settled_q1 <= pump_settled_in;
			pump_settled_q2 <= pump_settled_q1;
			pump_running_q1 <= pump_running_in;
			pump_running_q2 <= pump_running_q1;
		end
	end

	// ==========================================
	// reference chopping
	// hold low, hold high, or toggle every one or every two elementary conversions
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chop_q <= 1'b0;
			half_q <= 1'b0;
		end else if (clk_en) begin
			unique case (mode_q[5:4])
				2'b00: chop_q <= 1'b0;
				2'b01: chop_q <= 1'b1;
				2'b10: if (elem_conv_tick) chop_q <= ~chop_q;
				2'b11: begin
					if (elem_conv_tick) begin
						half_q <= ~half_q;
						if (half_q) chop_q <= ~chop_q;
					end
				end
			endcase
		end
	end
	assign chop_state = chop_q;

	// ==========================================
	// outputs to analog chain and pads
	logic def;
	assign def = mux_q[`SACR_B_DEF];

	assign osc_enable = osc_q[0];
	assign reference_out_on_pad0 = mode_q[`SACR_B_REF_OUT0];
	assign reference_in_on_pad1 = mode_q[`SACR_B_REF_IN1];
	assign pad0_oe = pad_out_q[`SACR_B_PAD0_DIR] && !reference_out_on_pad0;
	assign pad1_oe = pad_out_q[`SACR_B_PAD1_DIR] && !reference_in_on_pad1;
	assign pad0_out = pad_out_q[0];
	assign pad1_out = pad_out_q[1];
	assign pump_force_on_out = mode_q[`SACR_B_FORCE_ON];
	assign pump_force_off_out = mode_q[`SACR_B_FORCE_OFF] && !mode_q[`SACR_B_FORCE_ON];

	logic [7:0] cc, be, rs, gs, so;
	assign cc = def ? DEF_CONV_CTRL[7:0] : conv_ctrl_q;
	assign be = def ? DEF_BIAS_EN[7:0] : bias_en_q;
	assign rs = def ? DEF_RATE_S2[7:0] : rate_s2_q;
	assign gs = def ? DEF_GAIN_S13[7:0] : gain_s13_q;
	assign so = def ? DEF_S3_OFS[7:0] : s3_ofs_q;

	assign elementary_conv_count = cc[6:5];
	assign oversample_ratio_code = cc[4:2];
	assign continuous_mode = conv_ctrl_q[`SACR_B_CONTINUOUS_MODE];
	// bias code passed as current fraction
	assign converter_bias_sel = be[7:6];
	assign amplifier_bias_sel = be[5:4];
	assign stage_enable = be[3:0];
	assign sample_freq_sel = rs[7:6];
	assign stage2_gain = rs[5:4];
	assign stage2_offset = rs[3:0];
	assign stage1_gain = gs[7];
	assign stage3_gain = gs[6:0];
	assign stage3_offset_code = so[6:0];
	assign input_channel_sel = mux_q[5:1];
	assign reference_source_sel = mux_q[0];
endmodule : sacr_bank

// File: hw/sacr_pkg.sv
// types shared by the sensor converter control bank
// assumes sacr_regs.svh holds all numeric constants
package sacr_pkg;
	typedef enum logic [1:0] {
		SACR_CONV_IDLE = 2'b00,
		SACR_CONV_RUN = 2'b01,
		SACR_CONV_DONE = 2'b10
	} sacr_conv_state_type;

	typedef enum logic [1:0] {
		SACR_BIAS_QUARTER = 2'b00,
		SACR_BIAS_HALF = 2'b01,
		SACR_BIAS_RSVD = 2'b10,
		SACR_BIAS_FULL = 2'b11
	} sacr_bias_type;
endpackage : sacr_pkg

// File: hw/sacr_regs.svh
// register map constants for the sensor converter control bank
// assumes byte-wide registers, one per aligned 32-bit word on ahb-lite
`ifndef SACR_REGS_SVH
`define SACR_REGS_SVH

// printed offsets are register indices, byte address = index * 4
`define SACR_IDX_OSC 8'h30
`define SACR_IDX_PAD_OUT 8'h40
`define SACR_IDX_PAD_IN 8'h41
`define SACR_IDX_RES_LO 8'h50
`define SACR_IDX_RES_HI 8'h51
`define SACR_IDX_CONV_CTRL 8'h52
`define SACR_IDX_BIAS_EN 8'h53
`define SACR_IDX_RATE_S2 8'h54
`define SACR_IDX_GAIN_S13 8'h55
`define SACR_IDX_S3_OFS 8'h56
`define SACR_IDX_MUX_STAT 8'h57
`define SACR_IDX_MODE 8'h70

`define SACR_RST_OSC 8'h01
`define SACR_RST_PAD_OUT 8'h30
`define SACR_RST_CONV_CTRL 8'h28
`define SACR_RST_BIAS_EN 8'hF0
`define SACR_RST_RATE_S2 8'h00
`define SACR_RST_GAIN_S13 8'h0C
`define SACR_RST_S3_OFS 8'h00
`define SACR_RST_MUX 8'h00
`define SACR_RST_MODE 8'h04

// writable bit masks; unused bits are never stored
`define SACR_WM_OSC 8'h01
`define SACR_WM_PAD_OUT 8'h33
`define SACR_WM_CONV_CTRL 8'hFE
`define SACR_WM_S3_OFS 8'h7F
`define SACR_WM_MUX 8'h7F
`define SACR_WM_MODE 8'h3F

`define SACR_B_START 7
`define SACR_B_CONTINUOUS_MODE 1
`define SACR_B_PAD1_DIR 5
`define SACR_B_PAD0_DIR 4
`define SACR_B_FORCE_ON 3
`define SACR_B_FORCE_OFF 2
`define SACR_B_REF_OUT0 1
`define SACR_B_REF_IN1 0
`define SACR_B_DEF 6

`define SACR_HTRANS_NONSEQ 2'b10
`define SACR_HSIZE_WORD 3'b010
`define SACR_HRESP_OKAY 1'b0

`endif

// File: test/sacr_analog_model.sv
// behavioural converter chain facing the bank's analog side
// assumes the bench sets the result and the conversion length
`timescale 1ns/1ps
// ====================
// converter model
module sacr_analog_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire logic [15:0] result_in,
	input wire logic [3:0] delay,
	output logic conv_busy,
	output logic conv_done,
	output logic [15:0] conv_result,
	output logic elem_conv_tick,
	output logic pump_settled_in,
	output logic pump_running_in
);
	logic [3:0] cnt_q;
	assign pump_settled_in = 1'b1;
	assign pump_running_in = 1'b0;
	// result only valid with done; inverse otherwise so a stale capture shows
	assign conv_result = conv_done ? result_in : ~result_in;
	always_ff @(posedge clk) begin
		conv_done <= 1'b0;
		elem_conv_tick <= 1'b0;
		if (!rst_n) begin
			conv_busy <= 1'b0;
			cnt_q <= 4'h0;
		end else if (conv_start) begin
			conv_busy <= 1'b1;
			cnt_q <= delay;
		end else if (conv_busy) begin
			elem_conv_tick <= 1'b1;
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h0) begin
				conv_busy <= 1'b0;
				conv_done <= 1'b1;
			end
		end
	end
endmodule : sacr_analog_model

// File: test/sacr_bank_props.sv
// assertion checker for the sensor converter register bank
// assumes it sees only the bank's ports and is bound at the foot of this file
`timescale 1ns/1ps
`include "sacr_regs.svh"
// ====================
// checker
module sacr_bank_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic pad0_out,
	input wire logic pad0_oe,
	input wire logic pad1_oe,
	input wire logic osc_enable,
	input wire logic conv_start,
	input wire logic pump_force_on_out,
	input wire logic pump_force_off_out,
	input wire logic reference_out_on_pad0,
	input wire logic reference_in_on_pad1
);
	logic tk;
	assign tk = hsel && hready && htrans == `SACR_HTRANS_NONSEQ && hsize == `SACR_HSIZE_WORD && clk_en;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// address phase taken, then a running data phase
	sequence s_wr(idx);
		tk && hwrite && haddr[9:2] == idx ##1 clk_en;
	endsequence
	property p_osc;
		s_wr(`SACR_IDX_OSC) |=> osc_enable == $past(hwdata[0]);
	endproperty
	a_osc: assert property (p_osc) else $error("osc enable not written");
	property p_pad;
		s_wr(`SACR_IDX_PAD_OUT) |=> pad0_out == $past(hwdata[0]);
	endproperty
	a_pad: assert property (p_pad) else $error("pad value not written");
	property p_oe0;
		pad0_oe |-> !reference_out_on_pad0;
	endproperty
	a_oe0: assert property (p_oe0) else $error("pad0 driven during reference out");
	property p_oe1;
		pad1_oe |-> !reference_in_on_pad1;
	endproperty
	a_oe1: assert property (p_oe1) else $error("pad1 driven during reference in");
	property p_mode;
		s_wr(`SACR_IDX_MODE) |=> {reference_out_on_pad0, reference_in_on_pad1} == $past(hwdata[1:0]);
	endproperty
	a_mode: assert property (p_mode) else $error("reference pad select wrong");
	property p_force;
		s_wr(`SACR_IDX_MODE) |=> pump_force_on_out == $past(hwdata[3]);
	endproperty
	a_force: assert property (p_force) else $error("pump force on wrong");
	property p_prio;
		pump_force_on_out |-> !pump_force_off_out;
	endproperty
	a_prio: assert property (p_prio) else $error("force off beat force on");
	property p_start;
		s_wr(`SACR_IDX_CONV_CTRL) ##0 hwdata[7] |-> ##[1:4] conv_start;
	endproperty
	a_start: assert property (p_start) else $error("start write gave no pulse");
	property p_pulse;
		conv_start |=> !conv_start;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_frz;
		!clk_en |=> $stable(osc_enable) && $stable(pad0_out);
	endproperty
	a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule : sacr_bank_props

bind sacr_bank sacr_bank_props u_props (.*);

// File: test/testbench.sv
// self-checking bench for the register bank over ahb-lite
// assumes the converter model answers conversions; pads driven here
`timescale 1ns/1ps
`include "sacr_regs.svh"
// ====================
// bench
module testbench;
	import sacr_pkg::*;
	logic clk, rst_n, clk_en, hsel, hwrite, hreadyout, hresp, pad0_in, pad1_in, pad0_out, pad0_oe;
	logic pad1_out, pad1_oe, osc_enable, conv_start, conv_busy, conv_done, elem_conv_tick, chop_state;
	logic pump_settled_in, pump_running_in, pump_force_on_out, pump_force_off_out;
	logic reference_out_on_pad0, reference_in_on_pad1;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] conv_result, result_in, seed;
	logic [7:0] d;
	logic [3:0] delay;
	logic [2:0] oversample_ratio_code;
	logic [1:0] elementary_conv_count;
	wire hready = hreadyout;
	int n_errors, n_tests, i, k;
	logic [7:0] ri [11] = '{8'h30, 8'h40, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h70};
	logic [7:0] rv [11] = '{8'h01, 8'h30, 8'h00, 8'h00, 8'h28, 8'hF0, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h84};
	sacr_bank uut (.*, .continuous_mode(),
		.converter_bias_sel(), .amplifier_bias_sel(), .stage_enable(), .sample_freq_sel(), .stage2_gain(),
		.stage2_offset(), .stage1_gain(), .stage3_gain(), .stage3_offset_code(), .input_channel_sel(),
		.reference_source_sel());
	sacr_analog_model u_analog (.*);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// read-back value: unused bits read zero, status bits idle
	function automatic logic [31:0] exp_rd(input logic [7:0] idx, input logic [7:0] v);
		case (idx)
			8'h30: return {24'h0, v & 8'h01};
			8'h40: return {24'h0, v & 8'h33};
			8'h52: return {24'h0, v & 8'h7E};
			8'h56, 8'h57: return {24'h0, v & 8'h7F};
			8'h70: return {24'h0, v & 8'h3F | 8'h80};
			default: return {24'h0, v};
		endcase
	endfunction : exp_rd
	task automatic close_out;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic wt;
		int j;
		@(posedge clk);
		for (j = 0; j < 16 && hreadyout !== 1'b1; j++)
			@(posedge clk);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			close_out();
		end
	endtask : wt
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= `SACR_HTRANS_NONSEQ;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= w;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wt();
		rd = hrdata;
	endtask : bus
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
		bus(1'b0, idx, 32'h0);
		chk(nm, exp, rd);
	endtask : rdchk
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata, pad0_in, result_in, delay} = '0;
		{clk_en, pad1_in, hsize, seed, n_errors, n_tests} = {2'b11, `SACR_HSIZE_WORD, 16'h89F5, 64'h0};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ri[j]) rdchk(ri[j], {24'h0, rv[j]}, "reset value");
		rdchk(8'h41, 32'h2, "pad levels");
		rdchk(8'h31, 32'h0, "unmapped");
		$display("reset test done");
		repeat (3) foreach (ri[j]) begin
			seed = lfsr(seed);
			d = seed[7:0];
			bus(1'b1, ri[j], {seed, seed[15:8], d & ((ri[j] == 8'h52) ? 8'h7F : 8'hFF)});
			rdchk(ri[j], (ri[j] == 8'h50 || ri[j] == 8'h51) ? 32'h0 : exp_rd(ri[j], d), "readback");
		end
		$display("random test done");
		bus(1'b1, 8'h40, 32'h33);
		bus(1'b1, 8'h70, 32'h0);
		@(negedge clk);
		chk("pad drive", 32'hF, {28'h0, pad1_oe, pad0_oe, pad1_out, pad0_out});
		bus(1'b1, 8'h70, 32'h1F);
		// chop state follows the mode register one clock later
		repeat (2) @(negedge clk);
		chk("ref pads", 32'h0E, {26'h0, pad1_oe, pad0_oe, reference_out_on_pad0, reference_in_on_pad1,
			pump_force_on_out, pump_force_off_out});
		chk("chop hold", 32'h1, {31'h0, chop_state});
		@(posedge clk);
		clk_en <= 1'b0;
		// a write offered while frozen must not land
		bus(1'b1, 8'h40, 32'h0);
		clk_en <= 1'b1;
		rdchk(8'h40, 32'h33, "frozen write");
		$display("pad test done");
		for (k = 0; k < 2; k++) begin
			seed = lfsr(seed);
			result_in <= k ? seed : 16'h8000;
			delay <= k ? 4'hF : 4'h1;
			bus(1'b1, 8'h57, 32'h0);
			bus(1'b1, 8'h52, 32'hA8);
			rdchk(8'h57, 32'h80, "busy set");
			for (i = 0; i < 40 && rd[7] !== 1'b0; i++)
				bus(1'b0, 8'h57, 32'h0);
			chk("busy clear", 32'h0, rd);
			if (rd[7] !== 1'b0) close_out();
			rdchk(8'h50, {24'h0, result_in[7:0]}, "result low");
			rdchk(8'h51, {24'h0, result_in[15:8]}, "result high");
			rdchk(8'h52, 32'h28, "single done");
		end
		$display("conversion test done");
		bus(1'b1, 8'h52, 32'h7C);
		@(negedge clk);
		chk("conv fields", 32'h1F, {27'h0, elementary_conv_count, oversample_ratio_code});
		bus(1'b1, 8'h57, 32'h40);
		@(negedge clk);
		chk("default config", 32'h0A, {27'h0, elementary_conv_count, oversample_ratio_code});
		$display("default test done");
		close_out();
	end
endmodule : testbench
